/* File: bench/ppri_printer.sv */
// Printer side model: data pins, acknowledge pulses and the window sink.
// Assumes the bench sets the byte the printer drives and the sink stall.
`timescale 1ns/1ps

module ppri_printer (
  input  wire logic        clock,
  input  wire logic [7:0]  pins_out,
  input  wire logic        pins_oe,
  input  wire logic        strobe_n,
  input  wire logic [7:0]  drive_byte,
  input  wire logic        stall,
  input  wire logic        out_valid,
  input  wire logic [10:0] out_data,
  output logic [7:0]       pins_in,
  output logic             ack_n,
  output logic             ready
);
  logic [1:0]  ack_cnt  = 2'h0;
  logic        strobe_q = 1'b1;
  logic [10:0] got_q[$];

  ////////////////////////////////////////////////////////////////////////////
  // Released pins show the printer's byte, never the stale latch value.
  assign pins_in = pins_oe ? pins_out : drive_byte;
  assign ready   = !stall;
  assign ack_n   = (ack_cnt == 2'h0);

  ////////////////////////////////////////////////////////////////////////////
  // Each falling strobe is answered by a two cycle acknowledge pulse.
  always @(posedge clock) begin
    strobe_q <= strobe_n;
    if (!strobe_n && strobe_q) begin
      ack_cnt <= 2'h2;
    end else if (ack_cnt != 2'h0) begin
      ack_cnt <= ack_cnt - 2'h1;
    end
    if (out_valid && ready) begin
      got_q.push_back(out_data);
    end
  end
endmodule

/* File: bench/tb_ppri_top.sv */
// Self-checking bench of the printer port register interface.
// Assumes the printer model is compiled before this file.
`timescale 1ns/1ps

module tb_ppri_top;
  import ppri_pkg::*;
  localparam logic [15:0] BASE = 16'h0240;
  logic        clock = 1'b0;
  logic        rst_b = 1'b0;
  ppri_mode_t  mode  = PPRI_MODE_PRINTER;
  logic [15:0] hb = BASE, addr = BASE;
  logic [7:0]  wdata = 8'h00, drive = 8'h3c, dout, pins_out, pins_in;
  logic        wr_n = 1'b1, rd_n = 1'b1, stall = 1'b0, tmo = 1'b0;
  logic        fault_n = 1'b1, online = 1'b0, paper = 1'b0, nrdy_n = 1'b1;
  logic        oe, rdy, pins_oe, strb_n, adv_n, init_n, sel_n, irq, ack_n;
  logic        ev, er;
  logic [10:0] ed;
  logic [10:0] exp_w[3] = '{11'h381, 11'h433, 11'h7c4};
  int          bad_count = 0, n_tests = 0, cycles = 0, irqs = 0, lows = 0;

  ppri_top #(.AW(16)) ppri_top_inst (
    .clock(clock), .rst_b(rst_b), .port_mode(mode), .port_base(BASE),
    .host_addr(addr), .host_data_in(wdata), .host_write_n(wr_n),
    .host_read_n(rd_n), .host_data_out(dout), .host_data_oe(oe),
    .iochrdy(rdy), .port_data_pins_in(pins_in),
    .port_data_pins_out(pins_out), .port_data_pins_oe(pins_oe),
    .printer_fault_in_n(fault_n), .printer_online(online),
    .paper_out(paper), .char_accepted_n(ack_n),
    .printer_not_ready_n(nrdy_n), .epp_timeout_pulse(tmo),
    .data_latch_pulse_n(strb_n), .line_advance_out_n(adv_n),
    .printer_initialise_n(init_n), .printer_select_out_n(sel_n),
    .ack_irq(irq), .epp_out_valid(ev), .epp_out_ready(er),
    .epp_out_data(ed));

  ppri_printer ppri_printer_inst (
    .clock(clock), .pins_out(pins_out), .pins_oe(pins_oe),
    .strobe_n(strb_n), .drive_byte(drive), .stall(stall),
    .out_valid(ev), .out_data(ed), .pins_in(pins_in), .ack_n(ack_n),
    .ready(er));

  ////////////////////////////////////////////////////////////////////////////
  always #20 clock = ~clock;

  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (irq) irqs <= irqs + 1;
    if (!rdy) lows <= lows + 1;
    if (cycles == 20000) begin
      bad_count = bad_count + 1;
      finish_test();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [10:0] exp, got);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [2:0] ofs, input logic [7:0] d);
    int i;
    addr = hb + 16'(ofs);
    wdata = d;
    wr_n = 1'b0;
    repeat (2) @(negedge clock);
    for (i = 0; i < 50 && rdy !== 1'b1; i++) @(negedge clock);
    wr_n = 1'b1;
    repeat (2) @(negedge clock);
  endtask

  task automatic rd(input logic [2:0] ofs, output logic [7:0] d,
                    output logic o, input bit poke);
    addr = hb + 16'(ofs);
    rd_n = 1'b0;
    repeat (3) @(negedge clock);
    d = dout;
    o = oe;
    if (poke) begin
      nrdy_n = ~nrdy_n;
      repeat (2) @(negedge clock);
      chk("status held", {3'h0, d}, {3'h0, dout});
    end
    rd_n = 1'b1;
    repeat (2) @(negedge clock);
  endtask

  task automatic rchk(input string what, input logic [2:0] ofs,
                      input logic [7:0] exp);
    logic [7:0] d;
    logic       o;
    rd(ofs, d, o, 1'b0);
    chk(what, {3'h1, exp}, {2'h0, o, d});
  endtask

  function automatic logic [7:0] st(input logic t);
    return {~nrdy_n, ack_n, paper, online, fault_n, 2'h0, t};
  endfunction

  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [7:0] d;
    logic       o;
    int         k;
    repeat (8) @(negedge clock);
    rst_b = 1'b1;
    @(negedge clock);
    chk("ctl outs", 4'b1101, {strb_n, adv_n, init_n, sel_n});
    chk("pins reset", 8'h00, pins_out);
    rchk("ctl reset", 3'h2, 8'h00);
    $display("test reset done");
    wr(3'h0, 8'h5a);
    chk("pins", 8'h5a, pins_out);
    rchk("data rd", 3'h0, 8'h5a);
    mode = PPRI_MODE_EXTENDED;
    wr(3'h2, 8'h20);
    chk("pins oe ext", 1'b0, pins_oe);
    rchk("pins live", 3'h0, 8'h3c);
    mode = PPRI_MODE_PRINTER;
    repeat (2) @(negedge clock);
    chk("pins oe prn", 1'b1, pins_oe);
    hb = BASE + 16'h8;
    wr(3'h0, 8'hee);
    rd(3'h0, d, o, 1'b0);
    chk("outside oe", 1'b0, o);
    hb = BASE;
    chk("outside wr", 8'h5a, pins_out);
    $display("test data done");
    wr(3'h2, 8'hff);
    rchk("ctl ro bits", 3'h2, 8'h3f);
    chk("strobe", 1'b0, strb_n);
    chk("line adv", 1'b0, adv_n);
    chk("init sel", 2'b10, {init_n, sel_n});
    chk("irq on", 1, 11'(irqs));
    wr(3'h2, 8'h00);
    wr(3'h2, 8'h01);
    rd(3'h1, d, o, 1'b0);
    chk("ack low", 1'b0, d[6]);
    repeat (6) @(negedge clock);
    chk("irq off", 1, 11'(irqs));
    wr(3'h2, 8'h00);
    $display("test control done");
    for (k = 0; k < 16; k++) begin
      {fault_n, online, paper, nrdy_n} = k[3:0];
      rd(3'h1, d, o, 1'b0);
      chk("status", st(1'b0), d);
    end
    chk("ack bit", 1'b1, d[6]);
    rd(3'h1, d, o, 1'b1);
    $display("test status done");
    tmo = 1'b1;
    @(negedge clock);
    tmo = 1'b0;
    rchk("tmo prn", 3'h1, st(1'b0));
    wr(3'h4, 8'h11);
    chk("no push", 1'b0, ev);
    rd(3'h4, d, o, 1'b0);
    chk("win off", 1'b0, o);
    mode = PPRI_MODE_EPP;
    tmo = 1'b1;
    @(negedge clock);
    tmo = 1'b0;
    rchk("tmo set", 3'h1, st(1'b1));
    wr(3'h1, 8'hfe);
    rchk("tmo kept", 3'h1, st(1'b1));
    wr(3'h1, 8'h01);
    rchk("tmo clr", 3'h1, st(1'b0));
    $display("test timeout done");
    stall = 1'b1;
    wr(3'h3, 8'h81);
    wr(3'h4, 8'h33);
    fork
      wr(3'h7, 8'hc4);
      begin
        repeat (8) @(negedge clock);
        stall = 1'b0;
      end
    join
    repeat (4) @(negedge clock);
    chk("stretch", 1'b1, lows != 0);
    chk("words", 3, 11'(ppri_printer_inst.got_q.size()));
    for (k = 0; k < 3; k++) begin
      chk("word", exp_w[k], ppri_printer_inst.got_q[k]);
    end
    $display("test window done");
    finish_test();
  end
endmodule

/* File: logic/ppri_buf.sv */
// Two-entry buffer with valid and ready on both sides.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/1ps
`include "ppri_map.svh"

module ppri_buf #(
  parameter int W     = 11,
  parameter int DEPTH = `PPRI_BUF_DEPTH
) (
  input  wire logic         clock,
  input  wire logic         rst_b,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);

  generate
    if (DEPTH != 2 || W < 1) begin : g_bad
      $error("Buffer serves exactly two entries.");
    end
  endgenerate

  logic [W-1:0] tail_q;
  logic         tail_v_q;
  wire          push = in_valid && in_ready;
  wire          pop  = out_valid && out_ready;

  assign in_ready = !tail_v_q;

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      out_valid <= 1'b0;
      tail_v_q  <= 1'b0;
      out_data  <= '0;
      tail_q    <= '0;
    end else if (pop && tail_v_q) begin
      out_data <= tail_q;
      tail_v_q <= 1'b0;
    end else if (pop) begin
      out_valid <= push;
      out_data  <= in_data;
    end else if (push && !out_valid) begin
      out_valid <= 1'b1;
      out_data  <= in_data;
    end else if (push) begin
      tail_v_q <= 1'b1;
      tail_q   <= in_data;
    end
  end

endmodule

/* File: logic/ppri_map.svh */
// Register offsets, bit positions and reset values of the printer port.
// Assumes inclusion by bare name from the port's design files.
`ifndef PPRI_MAP_SVH
`define PPRI_MAP_SVH

`define PPRI_OFS_DATA    3'h0
`define PPRI_OFS_STATUS  3'h1
`define PPRI_OFS_CONTROL 3'h2
`define PPRI_OFS_EPP_LO  3'h3
`define PPRI_OFS_EPP_HI  3'h7

`define PPRI_ST_BUS_TIMEOUT_FLAG    0
`define PPRI_ST_FAULT    3
`define PPRI_ST_ONLINE   4
`define PPRI_ST_PAPER    5
`define PPRI_ST_ACK      6
`define PPRI_ST_READY    7

`define PPRI_CT_STROBE   0
`define PPRI_CT_LINEADV  1
`define PPRI_CT_INIT     2
`define PPRI_CT_SELECT   3
`define PPRI_CT_IRQEN    4
`define PPRI_CT_DIR      5
`define PPRI_CT_W        6

`define PPRI_DATA_RST    8'h00
`define PPRI_CTRL_RST    6'h00
`define PPRI_BUF_DEPTH   2

`endif

/* File: logic/ppri_pkg.sv */
// Types shared by the printer port register interface.
// Assumes the map header is compiled alongside.
package ppri_pkg;

  typedef enum logic [2:0] {
    PPRI_MODE_PRINTER  = 3'b001,
    PPRI_MODE_EXTENDED = 3'b010,
    PPRI_MODE_EPP      = 3'b100
  } ppri_mode_t;

endpackage

/* File: logic/ppri_top.sv */
// Register interface of a multi-mode printer port behind a strobed host bus.
// Assumes all inputs are synchronous to clock and a stable mode and base.
//
// Notes on behaviour
// - Eight byte offsets above a programmable base are decoded.
// - Offsets 0 to 2 work in all modes; 3 to 7 only in EPP mode.
// - Data and control are read/write always; status writable only in EPP.
// - Data latch takes host data at write strobe rise, drives pins, resets.
// - Reading offset 0 returns live pin levels, not latched.
// - Status value is frozen for the whole status read strobe.
// - Status bit 0 is set by an EPP bus timeout, else reads zero.
// - Timeout flag clears on reset or writing one; zero leaves it.
// - Status bits 1 and 2 always read zero.
// - Status bit 3 shows the active-low fault input level.
// - Status bit 4 shows the printer online input level.
// - Status bit 5 shows the paper out input level.
// - Status bit 6 shows the active-low acknowledge input level.
// - Status bit 7 shows the inverse of the busy input level.
// - Reset clears control bits 0 to 5; bits 6 and 7 read zero.
// - Control bit 0 drives the strobe output inverted.
// - Control bit 1 drives the line advance output inverted.
// - Bit 2 drives initialise unchanged; bit 3 drives select inverted.
// - With bit 4 set, acknowledge rising edges raise an interrupt.
// - Bit 5 sets pin direction except in printer mode, which drives out.
`timescale 1ns/1ps
`include "ppri_map.svh"

module ppri_top #(
  parameter int AW = 16
) (
  input  wire logic                   clock,
  input  wire logic                   rst_b,
  input  wire ppri_pkg::ppri_mode_t   port_mode,
  input  wire logic [AW-1:0]          port_base,
  input  wire logic [AW-1:0]          host_addr,
  input  wire logic [7:0]             host_data_in,
  input  wire logic                   host_write_n,
  input  wire logic                   host_read_n,
  output logic [7:0]                  host_data_out,
  output logic                        host_data_oe,
  output logic                        iochrdy,
  input  wire logic [7:0]             port_data_pins_in,
  output logic [7:0]                  port_data_pins_out,
  output logic                        port_data_pins_oe,
  input  wire logic                   printer_fault_in_n,
  input  wire logic                   printer_online,
  input  wire logic                   paper_out,
  input  wire logic                   char_accepted_n,
  input  wire logic                   printer_not_ready_n,
  input  wire logic                   epp_timeout_pulse,
  output logic                        data_latch_pulse_n,
  output logic                        line_advance_out_n,
  output logic                        printer_initialise_n,
  output logic                        printer_select_out_n,
  output logic                        ack_irq,
  output logic                        epp_out_valid,
  input  wire logic                   epp_out_ready,
  output logic [10:0]                 epp_out_data
);
  import ppri_pkg::*;

  // Control reset value as a vector, so that single bits can be picked.
  localparam logic [`PPRI_CT_W-1:0] ctrl_rst = `PPRI_CTRL_RST;

  generate
    if (AW < 4) begin : g_bad
      $error("Address must be wider than the register offset.");
    end
  endgenerate

  function automatic logic is_epp_ofs(input logic [2:0] ofs);
    is_epp_ofs = ofs >= `PPRI_OFS_EPP_LO && ofs <= `PPRI_OFS_EPP_HI;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Address decode.

  logic [7:0]                 data_latch_q;
  logic [`PPRI_CT_W-1:0]      ctrl_q;
  logic                       bus_timeout_flag_q;
  logic                       wr_n_prev_q;
  logic                       rd_n_prev_q;
  logic                       ack_prev_q;
  logic                       wr_hit_q;
  logic [2:0]                 wr_ofs_q;
  logic [7:0]                 wr_dat_q;
  logic                       pushed_q;

  wire       epp_mode = port_mode == PPRI_MODE_EPP;
  wire [2:0] ofs      = host_addr[2:0];
  wire       base_hit = host_addr[AW-1:3] == port_base[AW-1:3];
  wire       reg_ok   = base_hit && (!is_epp_ofs(ofs) || epp_mode);
  wire       wr_act   = !host_write_n;
  wire       rd_act   = !host_read_n;
  wire       wr_rise  = !wr_n_prev_q && host_write_n;
  wire       rd_fall  = rd_n_prev_q && rd_act;
  wire       ack_rise = !ack_prev_q && char_accepted_n;

  wire wr_commit = wr_rise && wr_hit_q;
  wire wr_data   = wr_commit && wr_ofs_q == `PPRI_OFS_DATA;
  wire wr_ctrl   = wr_commit && wr_ofs_q == `PPRI_OFS_CONTROL;
  wire wr_stat   = wr_commit && wr_ofs_q == `PPRI_OFS_STATUS && epp_mode;

  ////////////////////////////////////////////////////////////////////////////
  // Status, control and data next values.

  wire [7:0] status_live = {
    ~printer_not_ready_n,
    char_accepted_n,
    paper_out,
    printer_online,
    printer_fault_in_n,
    2'b00,
    bus_timeout_flag_q
  };

  wire bus_timeout_flag_clr = wr_stat && wr_dat_q[`PPRI_ST_BUS_TIMEOUT_FLAG];
  wire bus_timeout_flag_set = epp_mode && epp_timeout_pulse;
  wire bus_timeout_flag_d   = bus_timeout_flag_set || (bus_timeout_flag_q && !bus_timeout_flag_clr);

  wire [`PPRI_CT_W-1:0] ctrl_d =
    wr_ctrl ? wr_dat_q[`PPRI_CT_W-1:0] : ctrl_q;
  wire [7:0] data_d = wr_data ? wr_dat_q : data_latch_q;

  wire dir_out = port_mode == PPRI_MODE_PRINTER
                 || !ctrl_d[`PPRI_CT_DIR];

  wire [7:0] rd_mux =
    ofs == `PPRI_OFS_STATUS  ? status_live :
    ofs == `PPRI_OFS_CONTROL ? {2'b00, ctrl_q} :
    port_data_pins_in;
  wire rd_hold = ofs == `PPRI_OFS_STATUS && !rd_fall;

  ////////////////////////////////////////////////////////////////////////////
  // EPP window writes enter the buffer; the ready output stalls the host.

  wire epp_pend = wr_act && reg_ok && is_epp_ofs(ofs) && !pushed_q;
  logic buf_in_ready;

  ppri_buf #(
    .W     (11),
    .DEPTH (`PPRI_BUF_DEPTH)
  ) ppri_buf_inst (
    .clock     (clock),
    .rst_b     (rst_b),
    .in_valid  (epp_pend),
    .in_ready  (buf_in_ready),
    .in_data   ({ofs, host_data_in}),
    .out_valid (epp_out_valid),
    .out_ready (epp_out_ready),
    .out_data  (epp_out_data)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Registers.

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      wr_n_prev_q <= 1'b1;
      rd_n_prev_q <= 1'b1;
      ack_prev_q  <= 1'b1;
      wr_hit_q    <= 1'b0;
      wr_ofs_q    <= 3'h0;
      wr_dat_q    <= 8'h00;
      pushed_q    <= 1'b0;
    end else begin
      wr_n_prev_q <= host_write_n;
      rd_n_prev_q <= host_read_n;
      ack_prev_q  <= char_accepted_n;
      pushed_q    <= wr_act && (pushed_q || (epp_pend && buf_in_ready));
      if (wr_act) begin
        wr_hit_q <= reg_ok;
        wr_ofs_q <= ofs;
        wr_dat_q <= host_data_in;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      data_latch_q <= `PPRI_DATA_RST;
      ctrl_q       <= `PPRI_CTRL_RST;
      bus_timeout_flag_q      <= 1'b0;
    end else begin
      data_latch_q <= data_d;
      ctrl_q       <= ctrl_d;
      bus_timeout_flag_q      <= bus_timeout_flag_d;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      host_data_out <= 8'h00;
      host_data_oe  <= 1'b0;
      iochrdy       <= 1'b1;
      ack_irq       <= 1'b0;
    end else begin
      host_data_oe  <= rd_act && reg_ok;
      iochrdy       <= !(epp_pend && !buf_in_ready);
      ack_irq       <= ctrl_q[`PPRI_CT_IRQEN] && ack_rise;
      if (rd_act && !rd_hold) begin
        host_data_out <= reg_ok ? rd_mux : 8'h00;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      port_data_pins_out   <= `PPRI_DATA_RST;
      port_data_pins_oe    <= 1'b1;
      data_latch_pulse_n   <= ~ctrl_rst[`PPRI_CT_STROBE];
      line_advance_out_n   <= ~ctrl_rst[`PPRI_CT_LINEADV];
      printer_initialise_n <= ctrl_rst[`PPRI_CT_INIT];
      printer_select_out_n <= ~ctrl_rst[`PPRI_CT_SELECT];
    end else begin
      port_data_pins_out   <= data_d;
      port_data_pins_oe    <= dir_out;
      data_latch_pulse_n   <= ~ctrl_d[`PPRI_CT_STROBE];
      line_advance_out_n   <= ~ctrl_d[`PPRI_CT_LINEADV];
      printer_initialise_n <= ctrl_d[`PPRI_CT_INIT];
      printer_select_out_n <= ~ctrl_d[`PPRI_CT_SELECT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions.

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);

  a_data_pins_follow: assert property (
    wr_rise && wr_hit_q && wr_ofs_q == `PPRI_OFS_DATA
    |=> port_data_pins_out == $past(wr_dat_q) && data_latch_q == $past(wr_dat_q))
    else $error("Data latch did not take the written byte.");

  a_epp_gate_off: assert property (
    rd_act && base_hit && is_epp_ofs(ofs) && !epp_mode |=> !host_data_oe)
    else $error("EPP window answered outside EPP mode.");

  a_status_frozen: assert property (
    rd_act && $past(rd_act) && ofs == `PPRI_OFS_STATUS && $stable(ofs)
    && $past(host_data_oe) |=> $stable(host_data_out))
    else $error("Status changed during a read strobe.");

  a_bus_timeout_flag_set_wins: assert property (
    bus_timeout_flag_set |=> bus_timeout_flag_q)
    else $error("Timeout flag lost a set.");

  a_bus_timeout_flag_clear_one: assert property (
    bus_timeout_flag_clr && !bus_timeout_flag_set |=> !bus_timeout_flag_q ##1 (!bus_timeout_flag_q || $past(bus_timeout_flag_set)))
    else $error("Writing one did not clear the timeout flag.");

  a_bus_timeout_flag_zero_keep: assert property (
    wr_commit && wr_ofs_q == `PPRI_OFS_STATUS && !wr_dat_q[0] && bus_timeout_flag_q
    |=> bus_timeout_flag_q)
    else $error("Writing zero disturbed the timeout flag.");

  a_status_low_bits: assert property (
    rd_fall && reg_ok && ofs == `PPRI_OFS_STATUS |=> host_data_out[2:1] == 2'b00
    && host_data_out[7] == !$past(printer_not_ready_n))
    else $error("Status bits read wrong.");

  a_ctrl_high_zero: assert property (
    rd_act && reg_ok && ofs == `PPRI_OFS_CONTROL |=> host_data_out[7:6] == 2'b00)
    else $error("Control bits 6 and 7 read nonzero.");

  a_strobe_invert: assert property (
    ##1 data_latch_pulse_n == !ctrl_q[`PPRI_CT_STROBE])
    else $error("Strobe output not inverse of control bit 0.");

  a_printer_drives: assert property (
    port_mode == PPRI_MODE_PRINTER |=> port_data_pins_oe)
    else $error("Pins not driven in printer mode.");

  a_irq_on_rise: assert property (
    ack_rise && ctrl_q[`PPRI_CT_IRQEN] |=> ack_irq ##1 (!ack_irq || ack_rise))
    else $error("Acknowledge edge raised no interrupt.");

  a_stall_ready: assert property (
    epp_pend && !buf_in_ready |=> !iochrdy)
    else $error("Host not stalled on a full buffer.");

  a_ack_bit_live: assert property (
    rd_fall && reg_ok && ofs == `PPRI_OFS_STATUS
    |=> host_data_out[`PPRI_ST_ACK] == $past(char_accepted_n))
    else $error("Acknowledge status bit not the input level.");

  a_bus_timeout_flag_epp_only: assert property (
    !epp_mode && !bus_timeout_flag_q |=> !bus_timeout_flag_q)
    else $error("Timeout flag set outside EPP mode.");

  a_init_follow: assert property (
    wr_ctrl |=> printer_initialise_n == $past(wr_dat_q[`PPRI_CT_INIT]))
    else $error("Initialise output not the written control bit.");

  c_status_read: cover property (rd_fall && reg_ok && ofs == `PPRI_OFS_STATUS);
  c_epp_stall:   cover property (!iochrdy ##1 iochrdy);
  c_ack_irq:     cover property (ack_irq);
  c_bus_timeout_flag_clear: cover property (bus_timeout_flag_q ##1 !bus_timeout_flag_q);
  c_data_write:  cover property (wr_data);

endmodule
